// [rtl/serial_shift_pkg.sv]
package serial_shift_pkg;

  // ==========================================================
  // wire modes
  localparam logic [1:0] WM_OFF      = 2'h0;
  localparam logic [1:0] WM_THREE    = 2'h1;
  localparam logic [1:0] WM_TWO      = 2'h2;
  localparam logic [1:0] WM_TWO_HOLD = 2'h3;

  // ==========================================================
  // counter and data
  localparam int         CNT_W       = 4;
  localparam int         DATA_W      = 8;
  localparam logic [3:0] CNT_MAX     = 4'hF;
  localparam logic [3:0] CNT_ACK_PRE = 4'hE;
  localparam logic [7:0] DATA_RST    = 8'h00;
  localparam int         MSB_POS     = 7;

  // ==========================================================
  // timing
  localparam int CORE_CLK_KHZ   = 20000;
  localparam int START_DLY_NS   = 50;
  localparam int START_DLY_MAX  = 300;
  localparam int START_DLY_CYC  =
    (START_DLY_NS * CORE_CLK_KHZ + 999999) / 1000000;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [1:0] wire_mode;             // wire_mode_low_bit is bit 0
    logic       external_clock_select; // serial pin clocks the unit
    logic       clock_edge_select;     // ext: sample on falling edge
    logic       data_dir_en;           // port_direction_register bit
  } ctrl_t;

  typedef struct packed {
    logic             start_detect_flag;
    logic             counter_overflow_flag;
    logic             stop_flag;
    logic             collision;
    logic [CNT_W-1:0] count;
  } status_t;

endpackage : serial_shift_pkg

// [rtl/serial_shift_unit_two_wire.sv]
`timescale 1ns/1ps
`default_nettype none
module serial_shift_unit_two_wire
  import serial_shift_pkg::*;
#(
  parameter int DLY_CYC = START_DLY_CYC
) (
  input  wire logic              core_clk_in,    // system clock
  input  wire logic              rst_n_in,       // sync reset, low
  input  wire logic              ce_in,          // clock enable
  input  wire logic              link_clk_in,    // serial clock pin
  input  wire logic              sda_in,         // data_in_pin level
  input  wire ctrl_t             ctrl_in,        // mode and select
  input  wire logic              clk_strobe_in,  // software clock
  input  wire logic              toggle_strobe_in, // ext-mode strobe
  input  wire logic              timer_match_in, // internal clock src
  input  wire logic              data_wr_in,     // shift reg write
  input  wire logic [DATA_W-1:0] data_wdata_in,  // shift reg value
  input  wire logic              cnt_wr_in,      // counter write
  input  wire logic [CNT_W-1:0]  cnt_wdata_in,   // counter value
  input  wire logic              clr_start_in,   // clear start flag
  input  wire logic              clr_ovf_in,     // clear overflow
  input  wire logic              clr_stop_in,    // clear stop flag
  output var  logic [DATA_W-1:0] data_out,       // shift register
  output var  logic [DATA_W-1:0] buffer_out,     // byte at overflow
  output var  status_t           status_out,     // flags and count
  output var  logic              sda_out,        // data line value
  output var  logic              sda_oe_out,     // data line driven
  output var  logic              scl_out,        // clock line value
  output var  logic              scl_oe_out,     // clock held low
  output var  logic              do_out,         // three-wire data
  output var  logic              do_oe_out       // three-wire enable
);

  // ==========================================================
  // link domain: one toggle per serial clock edge, data captured
  // on the same edge; the core synchronises the toggles and reads the captured data unsynchronised
  logic [1:0] link_rst_q;
  logic       pos_tog_q;
  logic       pos_data_q;
  logic       neg_tog_q;
  logic       neg_data_q;

  always_ff @(posedge link_clk_in) begin
    link_rst_q <= {link_rst_q[0], rst_n_in};
  end

  always_ff @(posedge link_clk_in) begin
    if (!link_rst_q[1]) begin
      pos_tog_q  <= 1'b0;
      pos_data_q <= 1'b0;
    end else begin
      pos_tog_q  <= ~pos_tog_q;
      pos_data_q <= sda_in;
    end
  end

  always_ff @(negedge link_clk_in) begin
    if (!link_rst_q[1]) begin
      neg_tog_q  <= 1'b0;
      neg_data_q <= 1'b0;
    end else begin
      neg_tog_q  <= ~neg_tog_q;
      neg_data_q <= sda_in;
    end
  end

  // ==========================================================
  // core state
  typedef struct packed {
    logic [1:0]         pos_sync;
    logic [1:0]         neg_sync;
    logic               pos_last;
    logic               neg_last;
    logic [1:0]         sda_sync;
    logic [1:0]         scl_sync;
    logic [DLY_CYC-1:0] sda_dly;
    logic               sda_dly_last;
    logic [DATA_W-1:0]  sr;
    logic [DATA_W-1:0]  buf_r;
    logic               out_latch;
    logic [CNT_W-1:0]   cnt;
    logic               ovf;
    logic               start;
    logic               stop;
    logic               coll;
    logic               start_pend;
    logic               hold_start;
    logic               hold_ovf;
    logic               sda_oe;
    logic               scl_oe;
    logic               do_r;
    logic               do_oe;
  } state_t;

  state_t st_q;
  state_t st_d;

  // adds one or two edges to the counter, carry marks the wrap
  function automatic logic [CNT_W:0] count_add(
    input logic [CNT_W-1:0] c,
    input logic [1:0]       n
  );
    logic [CNT_W:0] s;
    s = {1'b0, c} + {{(CNT_W-1){1'b0}}, n};
    return s;
  endfunction : count_add

  logic           two_wire;
  logic           three_wire;
  logic           pos_ev;
  logic           neg_ev;
  logic           shift_ev;
  logic           latch_ev;
  logic           in_bit;
  logic [1:0]     inc;
  logic [CNT_W:0] cnt_sum;
  logic           wrap;
  logic           scl_lvl;
  logic           start_ev;
  logic           stop_ev;
  logic [DATA_W-1:0] sr_next;

  // ==========================================================
  // next state
  always_comb begin
    st_d = st_q;

    // synchronisers: the first stage feeds only the second
    st_d.pos_sync = {st_q.pos_sync[0], pos_tog_q};
    st_d.neg_sync = {st_q.neg_sync[0], neg_tog_q};
    st_d.sda_sync = {st_q.sda_sync[0], sda_in};
    st_d.scl_sync = {st_q.scl_sync[0], link_clk_in};
    st_d.pos_last = st_q.pos_sync[1];
    st_d.neg_last = st_q.neg_sync[1];

    two_wire   = ctrl_in.wire_mode[1];
    three_wire = (ctrl_in.wire_mode == WM_THREE);
    pos_ev     = st_q.pos_sync[1] ^ st_q.pos_last;
    neg_ev     = st_q.neg_sync[1] ^ st_q.neg_last;
    scl_lvl    = st_q.scl_sync[1];

    // clock source selection
    if (ctrl_in.external_clock_select) begin
      shift_ev = ctrl_in.clock_edge_select ? neg_ev : pos_ev;
      latch_ev = ctrl_in.clock_edge_select ? pos_ev : neg_ev;
      in_bit   = ctrl_in.clock_edge_select ? neg_data_q
                                           : pos_data_q;
      inc      = {1'b0, pos_ev} + {1'b0, neg_ev};
      if (clk_strobe_in && toggle_strobe_in) begin
        inc = {1'b0, pos_ev | neg_ev} + 2'h1;
      end
    end else begin
      shift_ev = ctrl_in.clock_edge_select ? timer_match_in
                                           : clk_strobe_in;
      latch_ev = 1'b1;  // latch transparent on internal clock
      in_bit   = st_q.sda_sync[1];
      inc      = {1'b0, shift_ev};
    end

    // shift left, msb first; a write in the same cycle wins
    sr_next = st_q.sr;
    if (data_wr_in) begin
      sr_next = data_wdata_in;
    end else if (shift_ev) begin
      sr_next = {st_q.sr[DATA_W-2:0], in_bit};
    end
    st_d.sr = sr_next;

    if (latch_ev || data_wr_in) begin
      st_d.out_latch = sr_next[MSB_POS];
    end

    // counter; a software write beats a counted edge
    cnt_sum = count_add(st_q.cnt, inc);
    wrap    = cnt_sum[CNT_W] && !cnt_wr_in;
    if (cnt_wr_in) begin
      st_d.cnt = cnt_wdata_in;
    end else begin
      st_d.cnt = cnt_sum[CNT_W-1:0];
    end
    if (wrap) begin
      st_d.buf_r = sr_next;
    end

    // delayed data line for the start and stop compare; the compare
    // runs on the core clock, so a stopped core clock misses a start
    st_d.sda_dly = DLY_CYC'({st_q.sda_dly, st_q.sda_sync[1]});
    st_d.sda_dly_last = st_q.sda_dly[DLY_CYC-1];
    start_ev = two_wire && scl_lvl && st_q.sda_dly_last
               && !st_q.sda_dly[DLY_CYC-1];
    stop_ev  = two_wire && scl_lvl && !st_q.sda_dly_last
               && st_q.sda_dly[DLY_CYC-1];
    if (!two_wire && ctrl_in.wire_mode != WM_OFF) begin
      start_ev = pos_ev || neg_ev;
    end
    if (ctrl_in.wire_mode == WM_OFF) begin
      start_ev = pos_ev || neg_ev;
    end

    // flags: a set in the same cycle as a clear wins
    if (clr_start_in) begin
      st_d.start = 1'b0;
    end
    if (start_ev) begin
      st_d.start = 1'b1;
    end
    if (clr_ovf_in) begin
      st_d.ovf = 1'b0;
    end
    if (wrap) begin
      st_d.ovf = 1'b1;
    end
    if (clr_stop_in) begin
      st_d.stop = 1'b0;
    end
    if (stop_ev) begin
      st_d.stop = 1'b1;
    end

    // clock hold after start: armed by the start, engaged at the
    // master's following falling clock edge
    if (start_ev && two_wire) begin
      st_d.start_pend = 1'b1;
    end
    if (st_q.start_pend && neg_ev && two_wire) begin
      st_d.hold_start = 1'b1;
      st_d.start_pend = 1'b0;
    end
    if (clr_start_in && !start_ev) begin
      st_d.hold_start = 1'b0;
      st_d.start_pend = 1'b0;
    end
    if (!two_wire) begin
      st_d.hold_start = 1'b0;
      st_d.start_pend = 1'b0;
    end

    // overflow hold only once the line is already low, so the
    // hold never carves an extra edge into a high clock
    st_d.hold_ovf = (ctrl_in.wire_mode == WM_TWO_HOLD)
                    && st_d.ovf
                    && (st_q.hold_ovf || !scl_lvl);

    // slave only pulls the clock low, never drives it high
    st_d.scl_oe = st_d.hold_start || st_d.hold_ovf;

    // open-drain data: low when bit 7 is zero and enabled; the
    // ack and a withheld ack are the byte software loads here
    st_d.sda_oe = two_wire && ctrl_in.data_dir_en
                  && !st_d.out_latch;
    st_d.do_r   = st_d.out_latch;
    st_d.do_oe  = three_wire && ctrl_in.data_dir_en;

    // collision is only meaningful in two-wire mode
    st_d.coll = two_wire && (st_q.out_latch != st_q.sda_sync[1]);
  end

  // ==========================================================
  // registers
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      st_q <= '0;
    end else if (ce_in) begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // outputs straight from flip-flops, except sda_out and scl_out tied low
  assign data_out   = st_q.sr;
  assign buffer_out = st_q.buf_r;
  assign status_out = '{start_detect_flag:     st_q.start,
                        counter_overflow_flag: st_q.ovf,
                        stop_flag:             st_q.stop,
                        collision:             st_q.coll,
                        count:                 st_q.cnt};
  assign sda_out    = 1'b0;
  assign sda_oe_out = st_q.sda_oe;
  assign scl_out    = 1'b0;
  assign scl_oe_out = st_q.scl_oe;
  assign do_out     = st_q.do_r;
  assign do_oe_out  = st_q.do_oe;

endmodule : serial_shift_unit_two_wire
`default_nettype wire

// [sim/serial_shift_unit_two_wire_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module serial_shift_checker
  import serial_shift_pkg::*;
(
  input wire logic              core_clk_in,   // clock
  input wire logic              rst_n_in,      // reset
  input wire logic              ce_in,         // enable
  input wire ctrl_t             ctrl_in,       // mode
  input wire logic              clk_strobe_in, // soft clock
  input wire logic              data_wr_in,    // load
  input wire logic [DATA_W-1:0] data_wdata_in, // value
  input wire logic              cnt_wr_in,     // load
  input wire logic [CNT_W-1:0]  cnt_wdata_in,  // value
  input wire logic              clr_start_in,  // clear
  input wire logic              clr_ovf_in,    // clear
  input wire logic [DATA_W-1:0] data_out,      // shift reg
  input wire status_t           status_out,    // flags
  input wire logic              sda_out,       // data
  input wire logic              scl_out,       // clock
  input wire logic              scl_oe_out     // hold
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  // ============================================================
  // helpers
  logic soft_tick;
  // only the software strobe clocks the unit in this selection
  assign soft_tick = ce_in && clk_strobe_in && !cnt_wr_in && !data_wr_in
    && !ctrl_in.external_clock_select && !ctrl_in.clock_edge_select;
  // ============================================================
  // properties
  a_data_load: assert property (ce_in && data_wr_in |=>
    data_out == $past(data_wdata_in)) else $error("load lost");
  a_count_load: assert property (ce_in && cnt_wr_in |=>
    status_out.count == $past(cnt_wdata_in)) else $error("count load");
  a_soft_wrap: assert property (soft_tick &&
    status_out.count == CNT_MAX |=> status_out.counter_overflow_flag
    && status_out.count == 4'h0) else $error("no wrap");
  a_shift_left: assert property (soft_tick |=>
    data_out[7:1] == $past(data_out[6:0])) else $error("bad shift");
  a_ovf_sticky: assert property (status_out.counter_overflow_flag &&
    !clr_ovf_in |=> status_out.counter_overflow_flag) else $error("ovf");
  a_start_sticky: assert property (status_out.start_detect_flag &&
    !clr_start_in |=> status_out.start_detect_flag) else $error("start");
  a_start_release: assert property (ce_in && clr_start_in &&
    ctrl_in.wire_mode[1] && !status_out.counter_overflow_flag
    |=> !scl_oe_out) else $error("hold kept");
  a_hold_cause: assert property ($rose(scl_oe_out) |->
    status_out.start_detect_flag || status_out.counter_overflow_flag)
    else $error("hold without cause");
  a_three_no_hold: assert property (ctrl_in.wire_mode == WM_THREE &&
    $past(ctrl_in.wire_mode) == WM_THREE |-> !scl_oe_out)
    else $error("three-wire hold");
  a_open_drain: assert property (!sda_out && !scl_out)
    else $error("line driven high");
  c_start: cover property ($rose(status_out.start_detect_flag));
  c_ovf: cover property ($rose(status_out.counter_overflow_flag));
  c_stop: cover property ($rose(status_out.stop_flag));
endmodule : serial_shift_checker
`default_nettype wire

// [sim/two_wire_master_model.sv]
`timescale 1ns/1ps
`default_nettype none
module two_wire_master_model (
  input  wire logic scl_oe_in,    // slave holds clock
  input  wire logic sda_oe_in,    // slave pulls data
  input  wire logic rx_in,        // level the master samples
  output wire logic scl_line_out, // wired clock
  output wire logic sda_line_out  // wired data
);
  logic tick   = 1'b0;
  logic scl_lo = 1'b0;
  logic sda_lo = 1'b0;
  // released lines return high through the pull-ups
  assign scl_line_out = !(scl_lo || scl_oe_in);
  assign sda_line_out = !(sda_lo || sda_oe_in);
  always #15 tick = ~tick;
  task automatic hold(input int n);
    repeat (n) @(posedge tick);
  endtask : hold
  task automatic rise(); // stretched clock must really go high
    int k;
    k = 0;
    scl_lo = 1'b0;
    while (!scl_line_out && k < 500) begin
      hold(1);
      k++;
    end
  endtask : rise
  // 240 ns halves keep the clock under half the core rate
  task automatic xfer_bit(input logic b, output logic s);
    sda_lo = !b;
    hold(8);
    rise();
    hold(4);
    s = rx_in;
    hold(4);
    scl_lo = 1'b1;
  endtask : xfer_bit
  task automatic start_cond(); // data falls while clock high
    sda_lo = 1'b1;
    hold(8);
    scl_lo = 1'b1;
    hold(8);
  endtask : start_cond
  task automatic stop_cond(); // transfer ends on stop
    sda_lo = 1'b1;
    hold(8);
    rise();
    hold(8);
    sda_lo = 1'b0;
    hold(8);
  endtask : stop_cond
  task automatic pin_edge(input int n, input int t);
    repeat (n) begin
      scl_lo = !scl_lo;
      #t;
    end
  endtask : pin_edge
endmodule : two_wire_master_model
`default_nettype wire

// [sim/serial_shift_unit_two_wire_test.sv]
`timescale 1ns/1ps
`default_nettype none
module serial_shift_unit_two_wire_test;
  import serial_shift_pkg::*;
  localparam logic [5:0] ST = 6'h20, OV = 6'h10, SP = 6'h08;
  localparam logic [5:0] DW = 6'h04, CW = 6'h02, STB = 6'h01;
  localparam ctrl_t C_TWO = '{WM_TWO_HOLD, 1'b1, 1'b0, 1'b0};
  localparam ctrl_t C_ACK = '{WM_TWO_HOLD, 1'b1, 1'b0, 1'b1};
  localparam ctrl_t C_3W  = '{WM_THREE, 1'b1, 1'b0, 1'b1};
  localparam ctrl_t C_TM  = '{WM_OFF, 1'b0, 1'b1, 1'b0};
  logic core_clk_in = 1'b0, rst_n_in = 1'b0, ce_in = 1'b1;
  logic clk_strobe_in = 1'b0, toggle_strobe_in = 1'b0;
  logic timer_match_in = 1'b0, data_wr_in = 1'b0, cnt_wr_in = 1'b0;
  logic clr_start_in = 1'b0, clr_ovf_in = 1'b0, clr_stop_in = 1'b0;
  logic [DATA_W-1:0] data_wdata_in = 8'h00;
  logic [CNT_W-1:0]  cnt_wdata_in = 4'h0;
  ctrl_t             ctrl_in = '0;
  logic [7:0]        rx;
  logic              ack;
  wire logic link_clk_in, sda_in, sda_out, sda_oe_out;
  wire logic scl_out, scl_oe_out, do_out, do_oe_out;
  wire logic [DATA_W-1:0] data_out, buffer_out;
  wire status_t status_out;
  int err_count = 0, n_compared = 0, cycles = 0;
  serial_shift_unit_two_wire dut (.core_clk_in, .rst_n_in, .ce_in,
    .link_clk_in, .sda_in, .ctrl_in, .clk_strobe_in, .toggle_strobe_in,
    .timer_match_in, .data_wr_in, .data_wdata_in, .cnt_wr_in,
    .cnt_wdata_in, .clr_start_in, .clr_ovf_in, .clr_stop_in, .data_out,
    .buffer_out, .status_out, .sda_out, .sda_oe_out, .scl_out,
    .scl_oe_out, .do_out, .do_oe_out);
  two_wire_master_model m (.scl_oe_in(scl_oe_out), .sda_oe_in(sda_oe_out),
    .rx_in(ctrl_in.wire_mode == WM_THREE ? do_out : sda_in),
    .scl_line_out(link_clk_in), .sda_line_out(sda_in));
  always #25 core_clk_in = ~core_clk_in;
  // ============================================================
  // tasks
  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run
  always @(posedge core_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t ns: got %h, expected %h", $time, seen, exp);
    end
  endtask : check
  // one software access: strobes live for exactly one core edge
  task automatic sw_op(input ctrl_t c, input logic [5:0] s,
                       input logic [7:0] dv, input logic [3:0] cv);
    @(posedge core_clk_in);
    ctrl_in <= c;
    {clr_start_in, clr_ovf_in, clr_stop_in, data_wr_in, cnt_wr_in,
      clk_strobe_in} <= s;
    data_wdata_in <= dv;
    cnt_wdata_in <= cv;
    @(posedge core_clk_in);
    {clr_start_in, clr_ovf_in, clr_stop_in, data_wr_in, cnt_wr_in,
      clk_strobe_in} <= 6'h00;
    @(posedge core_clk_in);
    #1;
  endtask : sw_op
  task automatic settle(); // covers the link synchroniser latency
    repeat (6) @(posedge core_clk_in);
    #1;
  endtask : settle
  task automatic byte_xfer(input logic [7:0] v, output logic [7:0] r);
    for (int i = 7; i >= 0; i--)
      m.xfer_bit(v[i], r[i]);
  endtask : byte_xfer
  // ============================================================
  // main sequence
  initial begin
    fork
      m.pin_edge(6, 20);
      repeat (3) @(posedge core_clk_in);
    join
    rst_n_in <= 1'b1;
    // link reset leaves only on serial clock rises; two rises here
    // keep the first real edges of a transfer from being swallowed
    m.pin_edge(4, 60);
    repeat (3) @(posedge core_clk_in);
    sw_op('0, DW | CW, 8'hA5, CNT_MAX);
    check(data_out, 8'hA5);
    sw_op('0, STB, 8'h00, 4'h0);
    check(status_out & 8'hEF, 8'h40);
    check(data_out, 8'h4B);
    @(posedge core_clk_in) ce_in <= 1'b0;
    sw_op('0, STB, 8'h00, 4'h0);
    check(data_out, 8'h4B);
    check(status_out & 8'h0F, 8'h00);
    @(posedge core_clk_in) ce_in <= 1'b1;
    sw_op(C_TWO, ST | OV | SP | CW, 8'h00, 4'h0);
    m.start_cond();
    settle();
    check(status_out & 8'hE0, 8'h80);
    check({7'h00, scl_oe_out}, 8'h01);
    sw_op(C_TWO, ST | CW, 8'h00, 4'h0);
    check({7'h00, scl_oe_out}, 8'h00);
    byte_xfer(8'hA4, rx);
    settle();
    check(status_out & 8'hEF, 8'h40);
    check(data_out, 8'hA4);
    check(buffer_out, 8'hA4);
    check({7'h00, scl_oe_out}, 8'h01);
    sw_op(C_ACK, OV | DW | CW, 8'h00, CNT_ACK_PRE);
    m.xfer_bit(1'b1, ack);
    settle();
    check({7'h00, ack}, 8'h00);
    check(status_out & 8'hEF, 8'h40);
    sw_op(C_TWO, OV, 8'h00, 4'h0);
    check({7'h00, scl_oe_out}, 8'h00);
    m.stop_cond();
    settle();
    check(status_out & 8'hA0, 8'h20);
    sw_op(C_3W, OV | CW, 8'h00, CNT_MAX);
    m.pin_edge(1, 240);
    settle();
    check(status_out & 8'h4F, 8'h40);
    sw_op(C_3W, OV | DW | CW, 8'h96, 4'h0);
    byte_xfer(8'h3C, rx);
    settle();
    check(status_out & 8'h4F, 8'h40);
    check(data_out, 8'h3C);
    check(rx, 8'h96);
    check({7'h00, do_oe_out}, 8'h01);
    sw_op(C_TM, OV | CW, 8'h00, CNT_MAX);
    @(posedge core_clk_in) timer_match_in <= 1'b1;
    @(posedge core_clk_in) timer_match_in <= 1'b0;
    settle();
    check(status_out & 8'h4F, 8'h40);
    check(data_out, 8'h78);
    complete_run();
  end
endmodule : serial_shift_unit_two_wire_test
bind serial_shift_unit_two_wire serial_shift_checker chk (.core_clk_in,
  .rst_n_in, .ce_in, .ctrl_in, .clk_strobe_in, .data_wr_in,
  .data_wdata_in, .cnt_wr_in, .cnt_wdata_in, .clr_start_in, .clr_ovf_in,
  .data_out, .status_out, .sda_out, .scl_out, .scl_oe_out);
`default_nettype wire
